// >>> include/odtt_consts.svh
// Constants for the outstanding transfer tracker: widths, codes, offsets and fields.
`ifndef ODTT_CONSTS_SVH
`define ODTT_CONSTS_SVH

// ************************************************************
// Field widths of the service parameters
// ************************************************************
`define ODTT_TAG_W    16
`define ODTT_RPID_W   32
`define ODTT_CHAN_W   16
`define ODTT_WORD_W   32
`define ODTT_LEN_W    8
`define ODTT_CTL_W    8
`define ODTT_RC_W     8
`define ODTT_UID_W    64

// ************************************************************
// Return codes
// ************************************************************
`define ODTT_RC_OK    8'h00
`define ODTT_RC_FAIL  8'hFE
`define ODTT_RC_INVAL 8'hFF

// ************************************************************
// Control parameter: sequence number bits that must stay zero
// ************************************************************
`define ODTT_CTL_FSN_MASK 8'h0F

// ************************************************************
// Register byte offsets
// ************************************************************
`define ODTT_ADDR_W      8
`define ODTT_REG_CMD     8'h00
`define ODTT_REG_TAG     8'h04
`define ODTT_REG_RPID    8'h08
`define ODTT_REG_CHAN    8'h0C
`define ODTT_REG_XID     8'h10
`define ODTT_REG_FLAGS   8'h14
`define ODTT_REG_OFFSET  8'h18
`define ODTT_REG_COUNT   8'h1C
`define ODTT_REG_START   8'h20
`define ODTT_REG_THRESH  8'h24
`define ODTT_REG_AVAIL   8'h28
`define ODTT_REG_CTLP    8'h2C
`define ODTT_REG_LEN     8'h30
`define ODTT_REG_MSGW1   8'h34
`define ODTT_REG_STATUS  8'h38
`define ODTT_REG_FIRST   8'h3C
`define ODTT_REG_PLACE   8'h40
`define ODTT_REG_MSGOUT  8'h44
`define ODTT_REG_CMPTAG  8'h48
`define ODTT_REG_CMPRPID 8'h4C

// ************************************************************
// Flag and status bit positions
// ************************************************************
`define ODTT_FLAGS_W     4
`define ODTT_FLG_INORDER 0
`define ODTT_FLG_REPLACE 1
`define ODTT_FLG_FAILED  2
`define ODTT_FLG_LAST    3
`define ODTT_ST_THR      8
`define ODTT_ST_USED_LSB 16
`define ODTT_CMD_W       3

// ************************************************************
// Table sizes
// ************************************************************
`define ODTT_ENTRIES 4
`define ODTT_SLOTS   2
`define ODTT_XID_W   8

`endif

// >>> include/odtt_pkg.sv
// Types shared by the outstanding transfer tracker.
`default_nettype none
package odtt_pkg;

   // Bus slave state, Gray coded along idle, read wait, read data.
   typedef enum logic [1:0] {
      ODTT_IDLE  = 2'b00,
      ODTT_RWAIT = 2'b01,
      ODTT_RDATA = 2'b11,
      ODTT_WDATA = 2'b10
   } odtt_ahb_e;

   // Commands written to the command register.
   typedef enum logic [2:0] {
      ODTT_CMD_NONE     = 3'h0,
      ODTT_CMD_START_RD = 3'h1,
      ODTT_CMD_START_WR = 3'h2,
      ODTT_CMD_CHAN_ADD = 3'h3,
      ODTT_CMD_CHAN_END = 3'h4,
      ODTT_CMD_DRDY     = 3'h5,
      ODTT_CMD_REPLY    = 3'h6
   } odtt_cmd_e;

endpackage
`default_nettype wire

// >>> logic/odtt_first.sv
// Lowest-index finder over a vector of hit bits.
`timescale 1ns/1ps
`default_nettype none

module odtt_first #(
   parameter int N  = 4,
   parameter int IW = (N > 1) ? $clog2(N) : 1
) (
   // Candidates
   input  wire logic [N-1:0]  hit_i,
   // Result
   output logic               found_o,
   output logic [IW-1:0]      idx_o
);

   always_comb begin
      found_o = 1'b0;
      idx_o   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (hit_i[i]) begin
            found_o = 1'b1;
            idx_o   = IW'(i);
         end
      end
   end

endmodule
`default_nettype wire

// >>> logic/odtt_tracker.sv
// Target-side outstanding transfer table behind an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "odtt_consts.svh"

// Overview of operation
// - Target read or write start allocates entry.
// - Completion frees the entry and signals done.
// - Tag stored unchanged, returned at completion.
// - Entry keeps chosen path id for completion.
// - Data replies checked against stored path id.
// - Channels added when ready, removed when done.
// - Channel completion searches table by channel.
// - Read data-ready adds a transfer identifier.
// - Identifier removed after final validated reply.
// - Only target keeps this table.
// - Return codes: 00 ok, FE fail, FF invalid.
// - Byte offset is four bytes.
// - Byte count four bytes, current portion only.
// - Control parameter sequence bits forced zero.
// - Message length is one byte.
// - Read channel value is two bytes.
// - Write channel value is two bytes.
// - Path id 4, tag 2, node id 8 bytes.
// - In-order flag selects offset placement.
// - Replace flag puts path id in bytes 4-7.
// - Start count sets first message byte count.
// - Threshold count triggers the next message.
module odtt_tracker
   import odtt_pkg::*;
#(
   parameter int NE = `ODTT_ENTRIES,
   parameter int NS = `ODTT_SLOTS,
   parameter int XW = `ODTT_XID_W
) (
   // Clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    nrst_i,
   // AHB-Lite slave
   input  wire logic                    hsel_i,
   input  wire logic [31:0]             haddr_i,
   input  wire logic [1:0]              htrans_i,
   input  wire logic                    hwrite_i,
   input  wire logic [2:0]              hsize_i,
   input  wire logic [31:0]             hwdata_i,
   input  wire logic                    hready_i,
   output logic      [31:0]             hrdata_o,
   output logic                         hreadyout_o,
   output logic                         hresp_o,
   // Completion indication toward the protocol layer
   output logic                         cmp_valid_o,
   output logic      [`ODTT_TAG_W-1:0]  cmp_tag_o,
   output logic      [`ODTT_RPID_W-1:0] cmp_rpid_o,
   output logic      [`ODTT_RC_W-1:0]   cmp_code_o
);

   localparam int EW = (NE > 1) ? $clog2(NE) : 1;
   localparam int SW = (NS > 1) ? $clog2(NS) : 1;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      odtt_ahb_e                                 st;
      logic                                      hready;
      logic [31:0]                               hrdata;
      logic [`ODTT_ADDR_W-1:0]                   addr;
      logic [NE-1:0]                             v;
      logic [NE-1:0]                             rd;
      logic [NE-1:0][`ODTT_TAG_W-1:0]            tag;
      logic [NE-1:0][`ODTT_RPID_W-1:0]           rpid;
      logic [NE-1:0][NS-1:0]                     chv;
      logic [NE-1:0][NS-1:0][`ODTT_CHAN_W-1:0]   ch;
      logic [NE-1:0][NS-1:0]                     xv;
      logic [NE-1:0][NS-1:0][XW-1:0]             xid;
      logic [`ODTT_TAG_W-1:0]                    a_tag;
      logic [`ODTT_RPID_W-1:0]                   a_rpid;
      logic [`ODTT_CHAN_W-1:0]                   a_ch;
      logic [XW-1:0]                             a_xid;
      logic [`ODTT_FLAGS_W-1:0]                  a_flg;
      logic [`ODTT_WORD_W-1:0]                   a_off;
      logic [`ODTT_WORD_W-1:0]                   a_cnt;
      logic [`ODTT_WORD_W-1:0]                   a_start;
      logic [`ODTT_WORD_W-1:0]                   a_thr;
      logic [`ODTT_WORD_W-1:0]                   a_avail;
      logic [`ODTT_CTL_W-1:0]                    a_ctl;
      logic [`ODTT_LEN_W-1:0]                    a_len;
      logic [`ODTT_WORD_W-1:0]                   a_msgw;
      logic [`ODTT_RC_W-1:0]                     rc;
      logic [`ODTT_WORD_W-1:0]                   first;
      logic [`ODTT_WORD_W-1:0]                   arrive;
      logic                                      cmp_v;
      logic [`ODTT_TAG_W-1:0]                    cmp_tag;
      logic [`ODTT_RPID_W-1:0]                   cmp_rpid;
      logic [`ODTT_RC_W-1:0]                     cmp_rc;
   } odtt_state_s;

   odtt_state_s q;
   odtt_state_s d;

   // ************************************************************
   // Table searches
   // ************************************************************
   logic [NE-1:0] free_hit_v;
   logic [NE-1:0] tag_hit_v;
   logic [NE-1:0] ch_hit_v;
   logic          free_hit;
   logic          tag_hit;
   logic          ch_hit;
   logic [EW-1:0] free_idx;
   logic [EW-1:0] tag_idx;
   logic [EW-1:0] ch_idx;

   function automatic logic [SW:0] slot_find(input logic [NS-1:0] hit);
      slot_find = '0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            slot_find = {1'b1, SW'(i)};
         end
      end
   endfunction

   always_comb begin
      for (int e = 0; e < NE; e++) begin
         free_hit_v[e] = !q.v[e];
         tag_hit_v[e]  = q.v[e] && (q.tag[e] == q.a_tag);
         ch_hit_v[e]   = 1'b0;
         for (int s = 0; s < NS; s++) begin
            if (q.v[e] && q.chv[e][s] && (q.ch[e][s] == q.a_ch)) begin
               ch_hit_v[e] = 1'b1;
            end
         end
      end
   end

   odtt_first #(.N(NE), .IW(EW)) u_free (.hit_i(free_hit_v), .found_o(free_hit), .idx_o(free_idx));
   odtt_first #(.N(NE), .IW(EW)) u_tag  (.hit_i(tag_hit_v),  .found_o(tag_hit),  .idx_o(tag_idx));
   odtt_first #(.N(NE), .IW(EW)) u_chan (.hit_i(ch_hit_v),   .found_o(ch_hit),   .idx_o(ch_idx));

   // ************************************************************
   // Next state
   // ************************************************************
   logic          acc;
   logic          wr_commit;
   logic [SW:0]   slot;
   logic [NS-1:0] mhit;
   odtt_cmd_e     cmd;

   assign acc       = hsel_i && htrans_i[1] && hready_i;
   assign wr_commit = (q.st == ODTT_WDATA);
   assign cmd       = odtt_cmd_e'(hwdata_i[`ODTT_CMD_W-1:0]);

   always_comb begin
      d       = q;
      d.cmp_v = 1'b0;
      slot    = '0;
      mhit    = '0;
      // Bus slave: reads take one wait state so a preceding write is always visible.
      case (q.st)
         ODTT_RWAIT: begin
            d.hready = 1'b1;
            d.st     = ODTT_RDATA;
            case (q.addr)
               `ODTT_REG_CMD:     d.hrdata = 32'(q.rc);
               `ODTT_REG_TAG:     d.hrdata = 32'(q.a_tag);
               `ODTT_REG_RPID:    d.hrdata = q.a_rpid;
               `ODTT_REG_CHAN:    d.hrdata = 32'(q.a_ch);
               `ODTT_REG_XID:     d.hrdata = 32'(q.a_xid);
               `ODTT_REG_FLAGS:   d.hrdata = 32'(q.a_flg);
               `ODTT_REG_OFFSET:  d.hrdata = q.a_off;
               `ODTT_REG_COUNT:   d.hrdata = q.a_cnt;
               `ODTT_REG_START:   d.hrdata = q.a_start;
               `ODTT_REG_THRESH:  d.hrdata = q.a_thr;
               `ODTT_REG_AVAIL:   d.hrdata = q.a_avail;
               `ODTT_REG_CTLP:    d.hrdata = 32'(q.a_ctl);
               `ODTT_REG_LEN:     d.hrdata = 32'(q.a_len);
               `ODTT_REG_MSGW1:   d.hrdata = q.a_msgw;
               `ODTT_REG_STATUS: begin
                  d.hrdata = 32'(q.rc);
                  d.hrdata[`ODTT_ST_THR] = (q.a_avail >= q.a_thr);
                  d.hrdata[`ODTT_ST_USED_LSB +: 8] = 8'($countones(q.v));
               end
               `ODTT_REG_FIRST:   d.hrdata = q.first;
               // In order: place by offset from buffer start; else at arrival point.
               `ODTT_REG_PLACE:   d.hrdata = q.a_flg[`ODTT_FLG_INORDER] ? q.a_off : q.arrive;
               `ODTT_REG_MSGOUT:  d.hrdata = q.a_flg[`ODTT_FLG_REPLACE] ? q.a_rpid : q.a_msgw;
               `ODTT_REG_CMPTAG:  d.hrdata = 32'(q.cmp_tag);
               `ODTT_REG_CMPRPID: d.hrdata = q.cmp_rpid;
               default:           d.hrdata = 32'h0000_0000;
            endcase
         end
         default: begin
            d.st     = ODTT_IDLE;
            d.hready = 1'b1;
            if (acc) begin
               d.addr = haddr_i[`ODTT_ADDR_W-1:0];
               if (hwrite_i) begin
                  d.st = ODTT_WDATA;
               end else begin
                  d.st     = ODTT_RWAIT;
                  d.hready = 1'b0;
               end
            end
         end
      endcase
      // Register writes and commands, committed at the end of the write data phase.
      if (wr_commit) begin
         case (q.addr)
            `ODTT_REG_TAG:    d.a_tag   = hwdata_i[`ODTT_TAG_W-1:0];
            `ODTT_REG_RPID:   d.a_rpid  = hwdata_i;
            `ODTT_REG_CHAN:   d.a_ch    = hwdata_i[`ODTT_CHAN_W-1:0];
            `ODTT_REG_XID:    d.a_xid   = hwdata_i[XW-1:0];
            `ODTT_REG_FLAGS:  d.a_flg   = hwdata_i[`ODTT_FLAGS_W-1:0];
            `ODTT_REG_OFFSET: d.a_off   = hwdata_i;
            `ODTT_REG_COUNT:  d.a_cnt   = hwdata_i;
            `ODTT_REG_START:  d.a_start = hwdata_i;
            `ODTT_REG_THRESH: d.a_thr   = hwdata_i;
            `ODTT_REG_AVAIL:  d.a_avail = hwdata_i;
            `ODTT_REG_CTLP:   d.a_ctl   = hwdata_i[`ODTT_CTL_W-1:0] & ~`ODTT_CTL_FSN_MASK;
            `ODTT_REG_LEN:    d.a_len   = hwdata_i[`ODTT_LEN_W-1:0];
            `ODTT_REG_MSGW1:  d.a_msgw  = hwdata_i;
            `ODTT_REG_CMD: begin
               d.rc = `ODTT_RC_INVAL;
               case (cmd)
                  ODTT_CMD_START_RD, ODTT_CMD_START_WR: begin
                     // The table lives only on this target side.
                     if (!free_hit) begin
                        d.rc = `ODTT_RC_FAIL;
                     end else begin
                        d.v[free_idx]    = 1'b1;
                        d.rd[free_idx]   = (cmd == ODTT_CMD_START_RD);
                        d.tag[free_idx]  = q.a_tag;
                        d.rpid[free_idx] = q.a_rpid;
                        d.chv[free_idx]  = '0;
                        d.xv[free_idx]   = '0;
                        d.first          = q.a_start;
                        d.arrive         = '0;
                        d.rc             = `ODTT_RC_OK;
                     end
                  end
                  ODTT_CMD_CHAN_ADD: begin
                     slot = slot_find(~q.chv[tag_idx]);
                     if (tag_hit && slot[SW]) begin
                        d.chv[tag_idx][slot[SW-1:0]] = 1'b1;
                        d.ch[tag_idx][slot[SW-1:0]]  = q.a_ch;
                        d.rc = `ODTT_RC_OK;
                     end
                  end
                  ODTT_CMD_CHAN_END: begin
                     for (int s = 0; s < NS; s++) begin
                        mhit[s] = q.chv[ch_idx][s] && (q.ch[ch_idx][s] == q.a_ch);
                     end
                     slot = slot_find(mhit);
                     if (ch_hit) begin
                        d.rc = `ODTT_RC_OK;
                        if ($countones(q.chv[ch_idx]) > 1) begin
                           d.chv[ch_idx][slot[SW-1:0]] = 1'b0;
                        end else begin
                           d.v[ch_idx]   = 1'b0;
                           d.chv[ch_idx] = '0;
                           d.xv[ch_idx]  = '0;
                           d.cmp_v       = 1'b1;
                           d.cmp_tag     = q.tag[ch_idx];
                           d.cmp_rpid    = q.rpid[ch_idx];
                           d.cmp_rc      = q.a_flg[`ODTT_FLG_FAILED] ? `ODTT_RC_FAIL : `ODTT_RC_OK;
                        end
                     end
                  end
                  ODTT_CMD_DRDY: begin
                     slot = slot_find(~q.xv[tag_idx]);
                     if (tag_hit && q.rd[tag_idx] && slot[SW]) begin
                        d.xv[tag_idx][slot[SW-1:0]]  = 1'b1;
                        d.xid[tag_idx][slot[SW-1:0]] = q.a_xid;
                        d.rc = `ODTT_RC_OK;
                     end
                  end
                  ODTT_CMD_REPLY: begin
                     for (int s = 0; s < NS; s++) begin
                        mhit[s] = q.xv[tag_idx][s] && (q.xid[tag_idx][s] == q.a_xid);
                     end
                     slot = slot_find(mhit);
                     if (tag_hit && (q.rpid[tag_idx] == q.a_rpid)) begin
                        d.rc     = `ODTT_RC_OK;
                        d.arrive = q.arrive + q.a_cnt;
                        if (q.a_flg[`ODTT_FLG_LAST] && slot[SW]) begin
                           d.xv[tag_idx][slot[SW-1:0]] = 1'b0;
                        end
                     end
                  end
                  default: d.rc = `ODTT_RC_INVAL;
               endcase
            end
            default: d.rc = q.rc;
         endcase
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q        <= '0;
         q.st     <= ODTT_IDLE;
         q.hready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign hrdata_o    = q.hrdata;
   assign hreadyout_o = q.hready;
   // Every transfer completes OKAY; unmapped reads return zero.
   assign hresp_o     = 1'b0;
   assign cmp_valid_o = q.cmp_v;
   assign cmp_tag_o   = q.cmp_tag;
   assign cmp_rpid_o  = q.cmp_rpid;
   assign cmp_code_o  = q.cmp_rc;

   // ************************************************************
   // Checks
   // ************************************************************
   logic cmd_fire;
   assign cmd_fire = wr_commit && (q.addr == `ODTT_REG_CMD);

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   property p_alloc;
      cmd_fire && ((cmd == ODTT_CMD_START_RD) || (cmd == ODTT_CMD_START_WR)) && free_hit
         |=> q.v[$past(free_idx)] && (q.rd[$past(free_idx)] == $past(cmd == ODTT_CMD_START_RD));
   endproperty
   a_alloc: assert property (p_alloc) else $error("start did not allocate an entry");

   property p_nofree;
      cmd_fire && ((cmd == ODTT_CMD_START_RD) || (cmd == ODTT_CMD_START_WR)) && !free_hit
         |=> (q.rc == `ODTT_RC_FAIL) && (q.v == $past(q.v)) && (q.first == $past(q.first));
   endproperty
   a_nofree: assert property (p_nofree) else $error("full table start not failed");

   property p_cmp_tag;
      cmd_fire && (cmd == ODTT_CMD_CHAN_END) && ch_hit && ($countones(q.chv[ch_idx]) == 1)
         |=> cmp_valid_o && (cmp_tag_o == $past(q.tag[ch_idx])) ##1 !cmp_valid_o;
   endproperty
   a_cmp_tag: assert property (p_cmp_tag) else $error("completion tag wrong");

   property p_free;
      cmd_fire && (cmd == ODTT_CMD_CHAN_END) && ch_hit && ($countones(q.chv[ch_idx]) == 1)
         |=> !q.v[$past(ch_idx)] && (cmp_rpid_o == $past(q.rpid[ch_idx]));
   endproperty
   a_free: assert property (p_free) else $error("completed entry not freed");

   property p_keep;
      cmd_fire && (cmd == ODTT_CMD_CHAN_END) && ch_hit && ($countones(q.chv[ch_idx]) > 1)
         |=> q.v[$past(ch_idx)] && !cmp_valid_o;
   endproperty
   a_keep: assert property (p_keep) else $error("entry freed with channels left");

   property p_reply_bad;
      cmd_fire && (cmd == ODTT_CMD_REPLY) && tag_hit && (q.rpid[tag_idx] != q.a_rpid)
         |=> (q.rc == `ODTT_RC_INVAL) && (q.xv == $past(q.xv));
   endproperty
   a_reply_bad: assert property (p_reply_bad) else $error("bad reply accepted");

   property p_drdy;
      cmd_fire && (cmd == ODTT_CMD_DRDY) && tag_hit && q.rd[tag_idx] && !(&q.xv[tag_idx])
         |=> $countones(q.xv[$past(tag_idx)]) == $countones($past(q.xv[tag_idx])) + 1;
   endproperty
   a_drdy: assert property (p_drdy) else $error("transfer id not added");

   property p_fsn;
      (q.a_ctl & `ODTT_CTL_FSN_MASK) == 8'h00;
   endproperty
   a_fsn: assert property (p_fsn) else $error("sequence bits of control not zero");

   property p_first;
      cmd_fire && (cmd == ODTT_CMD_START_RD) && free_hit |=> (q.first == $past(q.a_start)) [*2];
   endproperty
   a_first: assert property (p_first) else $error("first count not taken from start count");

   property p_rdwait;
      acc && !hwrite_i && (q.st != ODTT_RWAIT) |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_rdwait: assert property (p_rdwait) else $error("read wait state wrong");

endmodule
`default_nettype wire

// >>> testbench/odtt_pl_model.sv
// Protocol-layer model that records completion indications.
`timescale 1ns/1ps
`default_nettype none
module odtt_pl_model (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   // Completion indication
   input  wire logic        cmp_valid_i,
   input  wire logic [15:0] cmp_tag_i,
   input  wire logic [31:0] cmp_rpid_i,
   input  wire logic [7:0]  cmp_code_i,
   // Recorded view
   output var  int          n_cmp_o,
   output logic      [55:0] last_o
);
   // Counting every high cycle exposes a pulse that stands too long.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         n_cmp_o <= 0;
         last_o  <= '0;
      end else if (cmp_valid_i) begin
         n_cmp_o <= n_cmp_o + 1;
         last_o  <= {cmp_tag_i, cmp_rpid_i, cmp_code_i};
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Register-level testbench for the outstanding transfer tracker.
`timescale 1ns/1ps
`default_nettype none
`include "odtt_consts.svh"
module tb_top;
   import odtt_pkg::*;
   logic        clk_sys_i, nrst_i, hsel, hwrite, cv, hresp;
   logic [31:0] haddr, hwdata, hrdata, crpid;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] ctag;
   logic [7:0]  ccode;
   logic [55:0] last;
   wire         hready;
   int          n_fail, tests_run, n_cmp;
   odtt_tracker odtt_tracker_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .cmp_valid_o(cv), .cmp_tag_o(ctag),
      .cmp_rpid_o(crpid), .cmp_code_o(ccode));
   odtt_pl_model odtt_pl_model_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmp_valid_i(cv),
      .cmp_tag_i(ctag), .cmp_rpid_i(crpid), .cmp_code_i(ccode), .n_cmp_o(n_cmp), .last_o(last));
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   task automatic stop_test();
      $display("Counts: %0d compared, %0d mismatched", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // A slave that never answers would hang the run, so every wait is bounded.
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         chk("hready", 1, hready);
         stop_test();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      chk("response", 0, hresp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic cmd(input logic [2:0] c);
      wr(`ODTT_REG_CMD, {29'h0, c});
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(nm, e, r & m);
   endtask
   task automatic rc_chk(input logic [7:0] e);
      rd_chk("return code", `ODTT_REG_CMD, 32'hFF, {24'h0, e});
   endtask
   task automatic cmp_chk(input int n, input logic [55:0] e);
      repeat (2) @(posedge clk_sys_i);
      chk("completion count", n, n_cmp);
      chk("completion fields", e, last);
   endtask
   initial begin
      {nrst_i, hsel, haddr, htrans, hwrite, hwdata, n_fail, tests_run} = '0;
      hsize = 3'h2;
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd_chk("status at reset", `ODTT_REG_STATUS, '1, 32'h100);
      $display("Test reset finished");
      wr(`ODTT_REG_RPID, 32'hA5A50001);
      wr(`ODTT_REG_START, 32'h40);
      for (int i = 0; i < 4; i++) begin
         wr(`ODTT_REG_TAG, 32'h1230 + i);
         cmd((i % 2) ? ODTT_CMD_START_WR : ODTT_CMD_START_RD);
         rc_chk(`ODTT_RC_OK);
      end
      rd_chk("first count", `ODTT_REG_FIRST, '1, 32'h40);
      wr(`ODTT_REG_TAG, 32'h1299);
      wr(`ODTT_REG_START, 32'h99);
      cmd(ODTT_CMD_START_RD);
      rd_chk("status when full", `ODTT_REG_STATUS, '1, 32'h000401FE);
      rd_chk("first kept", `ODTT_REG_FIRST, '1, 32'h40);
      $display("Test allocation finished");
      wr(`ODTT_REG_TAG, 32'h1230);
      for (int c = 7; c < 10; c++) begin
         wr(`ODTT_REG_CHAN, c);
         cmd(ODTT_CMD_CHAN_ADD);
         rc_chk((c < 9) ? `ODTT_RC_OK : `ODTT_RC_INVAL);
      end
      wr(`ODTT_REG_CHAN, 7);
      cmd(ODTT_CMD_CHAN_END);
      cmp_chk(0, 56'h0);
      wr(`ODTT_REG_CHAN, 8);
      cmd(ODTT_CMD_CHAN_END);
      cmp_chk(1, {16'h1230, 32'hA5A50001, `ODTT_RC_OK});
      rd_chk("entries in use", `ODTT_REG_STATUS, 32'hFF0000, 32'h30000);
      rd_chk("completion tag", `ODTT_REG_CMPTAG, '1, 32'h1230);
      wr(`ODTT_REG_TAG, 32'h1233);
      wr(`ODTT_REG_CHAN, 5);
      cmd(ODTT_CMD_CHAN_ADD);
      wr(`ODTT_REG_FLAGS, 32'h4);
      cmd(ODTT_CMD_CHAN_END);
      cmp_chk(2, {16'h1233, 32'hA5A50001, `ODTT_RC_FAIL});
      $display("Test completion finished");
      wr(`ODTT_REG_FLAGS, 32'h0);
      wr(`ODTT_REG_TAG, 32'h1231);
      wr(`ODTT_REG_XID, 32'h3);
      cmd(ODTT_CMD_DRDY);
      rc_chk(`ODTT_RC_INVAL);
      wr(`ODTT_REG_TAG, 32'h1232);
      cmd(ODTT_CMD_DRDY);
      rc_chk(`ODTT_RC_OK);
      wr(`ODTT_REG_RPID, 32'h1);
      cmd(ODTT_CMD_REPLY);
      rc_chk(`ODTT_RC_INVAL);
      wr(`ODTT_REG_RPID, 32'hA5A50001);
      wr(`ODTT_REG_COUNT, 32'h10);
      cmd(ODTT_CMD_REPLY);
      rc_chk(`ODTT_RC_OK);
      wr(`ODTT_REG_FLAGS, 32'h8);
      cmd(ODTT_CMD_REPLY);
      rc_chk(`ODTT_RC_OK);
      rd_chk("arrival point", `ODTT_REG_PLACE, '1, 32'h20);
      // Both identifier slots must be free again once the final reply removed the first one.
      cmd(ODTT_CMD_DRDY);
      rc_chk(`ODTT_RC_OK);
      cmd(ODTT_CMD_DRDY);
      rc_chk(`ODTT_RC_OK);
      cmd(ODTT_CMD_DRDY);
      rc_chk(`ODTT_RC_INVAL);
      $display("Test reply finished");
      wr(`ODTT_REG_OFFSET, 32'hDEADBEEF);
      rd_chk("offset", `ODTT_REG_OFFSET, '1, 32'hDEADBEEF);
      wr(`ODTT_REG_COUNT, 32'h89ABCDEF);
      rd_chk("count", `ODTT_REG_COUNT, '1, 32'h89ABCDEF);
      wr(`ODTT_REG_CTLP, 32'hFF);
      rd_chk("control", `ODTT_REG_CTLP, '1, 32'hF0);
      wr(`ODTT_REG_LEN, 32'h1FF);
      rd_chk("length", `ODTT_REG_LEN, '1, 32'hFF);
      wr(`ODTT_REG_FLAGS, 32'h1);
      rd_chk("placement", `ODTT_REG_PLACE, '1, 32'hDEADBEEF);
      wr(`ODTT_REG_MSGW1, 32'h11223344);
      wr(`ODTT_REG_FLAGS, 32'h2);
      rd_chk("message replaced", `ODTT_REG_MSGOUT, '1, 32'hA5A50001);
      wr(`ODTT_REG_FLAGS, 32'h0);
      rd_chk("message kept", `ODTT_REG_MSGOUT, '1, 32'h11223344);
      wr(`ODTT_REG_THRESH, 32'h20);
      wr(`ODTT_REG_AVAIL, 32'h1F);
      rd_chk("below threshold", `ODTT_REG_STATUS, 32'h100, 32'h0);
      wr(`ODTT_REG_AVAIL, 32'h20);
      rd_chk("at threshold", `ODTT_REG_STATUS, 32'h100, 32'h100);
      wr(8'h80, 32'h5A5A5A5A);
      rd_chk("unmapped", 8'h80, '1, 32'h0);
      cmd(3'h7);
      rc_chk(`ODTT_RC_INVAL);
      $display("Test parameters finished");
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd_chk("status after reset", `ODTT_REG_STATUS, '1, 32'h100);
      $display("Test second reset finished");
      stop_test();
   end
endmodule
`default_nettype wire
